// *** rtl/nbwp_top.sv ***
// Block write protection: serial front end, lock array and range decode
`timescale 1ns/10ps
`include "nbwp_map.svh"

module nbwp_top #(
    parameter int LOCK_BUSY_NS = 1000,
    parameter int RESET_BUSY_NS = 1000,
    parameter int PROG_BUSY_NS = 1000,
    parameter int ERASE_BUSY_NS = 1000
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    output logic so,
    output logic so_oe
);
    import nbwp_pkg::*;

    localparam int LOCK_CYC = (LOCK_BUSY_NS + `NBWP_CLK_NS - 1) / `NBWP_CLK_NS;
    localparam int RST_CYC = (RESET_BUSY_NS + `NBWP_CLK_NS - 1) / `NBWP_CLK_NS;
    localparam int PROG_CYC = (PROG_BUSY_NS + `NBWP_CLK_NS - 1) / `NBWP_CLK_NS;
    localparam int ERS_CYC = (ERASE_BUSY_NS + `NBWP_CLK_NS - 1) / `NBWP_CLK_NS;

    if (LOCK_CYC < 2 || RST_CYC < 1 || PROG_CYC < 1 || ERS_CYC < 1 ||
        LOCK_CYC > 1048576 || RST_CYC > 1048576 ||
        PROG_CYC > 1048576 || ERS_CYC > 1048576) begin : g_chk
        $error("nbwp_top: busy times out of range");
    end

    function automatic logic is_lock_op(input logic [7:0] op);
        is_lock_op = (op == `NBWP_OP_BLK_LOCK) ||
                     (op == `NBWP_OP_BLK_UNLOCK) ||
                     (op == `NBWP_OP_GLB_LOCK) || (op == `NBWP_OP_GLB_UNLOCK);
    endfunction

    function automatic logic [5:0] cmd_bits(input logic [7:0] op);
        if (op == `NBWP_OP_BLK_LOCK || op == `NBWP_OP_BLK_UNLOCK ||
            op == `NBWP_OP_PROG_EXEC || op == `NBWP_OP_BLK_ERASE) begin
            cmd_bits = `NBWP_BITS_ADDR;
        end else if (op == `NBWP_OP_SETF) begin
            cmd_bits = `NBWP_BITS_FEAT;
        end else begin
            cmd_bits = `NBWP_BITS_OP;
        end
    endfunction

    function automatic logic range_hit(input logic [16:0] row,
                                       input logic [7:0] rc);
        logic [2:0] bp;
        logic [17:0] sz;
        logic [17:0] r;
        bp = rc[`NBWP_RNG_BP_HI:`NBWP_RNG_BP_LO];
        sz = `NBWP_ONE_ROW << (`NBWP_FRAC_SHIFT + {2'h0, bp});
        r = {1'b0, row};
        if (bp == `NBWP_BP_NONE) begin
            range_hit = 1'b0;
        end else if (bp == `NBWP_BP_ALL) begin
            range_hit = 1'b1;
        end else if (!rc[`NBWP_RNG_CMP]) begin
            if (rc[`NBWP_RNG_INV]) begin
                range_hit = (r < sz);
            end else begin
                range_hit = (r >= `NBWP_ROWS - sz);
            end
        end else if (bp == `NBWP_BP_BLOCK0) begin
            range_hit = (r < `NBWP_BLOCK0_ROWS);
        end else if (rc[`NBWP_RNG_INV]) begin
            range_hit = (r >= sz);
        end else begin
            range_hit = (r < `NBWP_ROWS - sz);
        end
    endfunction

    // ---------------- Serial clock domain ----------------
    logic fresh_q;
    logic [5:0] cnt_q;
    logic [5:0] idx;
    logic [7:0] op_q;
    logic [23:0] addr_q;
    logic [7:0] rfa_q;
    logic [10:0] qblk_q;
    logic [7:0] byte_q;
    logic so_q;
    logic oe_q;
    logic ph;
    logic [7:0] rd_byte;
    nbwp_feat_s feat_m;
    nbwp_feat_s feat_s;

    // Marks a frame's first edge; the clock may stand still between frames
    always_ff @(posedge sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh_q <= 1'b1;
        end else begin
            fresh_q <= 1'b0;
        end
    end

    assign idx = fresh_q ? 6'h00 : cnt_q;

    // Saturates into a loop of eight so repeated byte reads keep their phase
    always_ff @(posedge sclk) begin
        cnt_q <= (idx == `NBWP_CNT_TOP) ? `NBWP_CNT_WRAP : idx + 6'h01;
    end

    always_ff @(posedge sclk) begin
        if (idx < `NBWP_BITS_OP) begin
            op_q <= {op_q[6:0], si};
        end else if (idx < `NBWP_BITS_ADDR) begin
            addr_q <= {addr_q[22:0], si};
        end
    end

    always_ff @(posedge sclk) begin
        if (idx == `NBWP_EDGE_FA) begin
            rfa_q <= {addr_q[6:0], si};
        end
    end

    // Block number is taken before the dummy bits so the lookup can settle
    always_ff @(posedge sclk) begin
        if (idx == `NBWP_EDGE_QBLK) begin
            qblk_q <= {addr_q[9:0], si};
        end
    end

    nbwp_sync #(.W(25), .RST_BIT(1'b0)) u_feat_sync (
        .clk(sclk),
        .rst(1'b0),
        .d(feat_m),
        .q(feat_s)
    );

    always_comb begin
        rd_byte = 8'h00;
        if (op_q == `NBWP_OP_GETF) begin
            if (rfa_q == `NBWP_FA_RANGE) begin
                rd_byte = feat_s.rng;
            end else if (rfa_q == `NBWP_FA_CONFIG) begin
                rd_byte = feat_s.cfg;
            end else if (rfa_q == `NBWP_FA_STATUS) begin
                rd_byte = feat_s.status;
            end
        end else if (op_q == `NBWP_OP_LOCK_QUERY) begin
            rd_byte = {7'h00, feat_s.qlock};
        end
    end

    assign ph = !fresh_q &&
        ((op_q == `NBWP_OP_GETF && cnt_q >= `NBWP_OUT_FEAT) ||
         (op_q == `NBWP_OP_LOCK_QUERY && cnt_q >= `NBWP_OUT_QUERY));

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= ph;
        end
    end

    always_ff @(negedge sclk) begin
        if (cnt_q[2:0] == 3'h0) begin
            byte_q <= rd_byte;
            so_q <= rd_byte[7];
        end else begin
            so_q <= byte_q[~cnt_q[2:0]];
        end
    end

    assign so = so_q;
    assign so_oe = oe_q && !cs_n;

    // ---------------- Main clock domain ----------------
    nbwp_state_e state_q;
    logic [19:0] busy_q;
    logic [2047:0] lock_q;
    logic [7:0] range_q;
    logic [7:0] cfg_q;
    logic wel_q;
    logic efail_q;
    logic pfail_q;
    logic cs_s;
    logic cs_d1_q;
    logic exec;
    logic take;
    logic idle;
    logic op_in_progress;
    logic prot_row;
    logic [10:0] blk_a;
    logic [16:0] row_a;
    logic [7:0] status;
    nbwp_frame_s fr;

    nbwp_sync #(.W(1), .RST_BIT(1'b1)) u_cs_sync (
        .clk(mclk),
        .rst(rst),
        .d(cs_n),
        .q(cs_s)
    );

    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_d1_q <= 1'b1;
        end else begin
            cs_d1_q <= cs_s;
        end
    end

    // Frame fields are read only after chip select rises, while sclk is still
    assign fr = '{op: op_q, addr: addr_q, nbits: cnt_q};
    assign exec = cs_s && !cs_d1_q;
    assign take = exec && (fr.nbits >= cmd_bits(fr.op));
    assign idle = (state_q == NBWP_IDLE);
    assign op_in_progress = !idle;
    assign blk_a = fr.addr[22:12];
    assign row_a = fr.addr[16:0];
    assign prot_row = cfg_q[`NBWP_CFG_SCHEME]
        ? lock_q[row_a[16:6]]
        : range_hit(row_a, range_q);

    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_q <= '1;
        end else if (take && fr.op == `NBWP_OP_RESET) begin
            lock_q <= '1;
        end else if (take && idle) begin
            if (fr.op == `NBWP_OP_GLB_LOCK) begin
                lock_q <= '1;
            end else if (fr.op == `NBWP_OP_GLB_UNLOCK) begin
                lock_q <= '0;
            end else if (fr.op == `NBWP_OP_BLK_LOCK) begin
                lock_q[blk_a] <= 1'b1;
            end else if (fr.op == `NBWP_OP_BLK_UNLOCK) begin
                lock_q[blk_a] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            range_q <= `NBWP_RANGE_RST;
            cfg_q <= `NBWP_CONFIG_RST;
        end else if (take && idle && fr.op == `NBWP_OP_SETF) begin
            if (fr.addr[15:8] == `NBWP_FA_RANGE) begin
                range_q <= fr.addr[7:0];
            end else if (fr.addr[15:8] == `NBWP_FA_CONFIG) begin
                cfg_q <= fr.addr[7:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || (take && fr.op == `NBWP_OP_RESET)) begin
            wel_q <= 1'b0;
            efail_q <= 1'b0;
            pfail_q <= 1'b0;
        end else if (take && idle) begin
            if (fr.op == `NBWP_OP_WREN) begin
                wel_q <= 1'b1;
            end else if (fr.op == `NBWP_OP_WRDI) begin
                wel_q <= 1'b0;
            end else if (fr.op == `NBWP_OP_PROG_EXEC && wel_q) begin
                wel_q <= 1'b0;
                pfail_q <= prot_row;
            end else if (fr.op == `NBWP_OP_BLK_ERASE && wel_q) begin
                wel_q <= 1'b0;
                efail_q <= prot_row;
            end
        end
    end

    // Program and erase without the write enable latch are dropped silently
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q <= NBWP_IDLE;
            busy_q <= 20'h00000;
        end else if (take && fr.op == `NBWP_OP_RESET) begin
            state_q <= NBWP_BUSY;
            busy_q <= 20'(RST_CYC - 1);
        end else if (take && idle && is_lock_op(fr.op)) begin
            state_q <= NBWP_BUSY;
            busy_q <= 20'(LOCK_CYC - 1);
        end else if (take && idle && wel_q && fr.op == `NBWP_OP_PROG_EXEC) begin
            state_q <= NBWP_BUSY;
            busy_q <= 20'(PROG_CYC - 1);
        end else if (take && idle && wel_q && fr.op == `NBWP_OP_BLK_ERASE) begin
            state_q <= NBWP_BUSY;
            busy_q <= 20'(ERS_CYC - 1);
        end else if (state_q == NBWP_BUSY) begin
            if (busy_q == 20'h00000) begin
                state_q <= NBWP_IDLE;
            end else begin
                busy_q <= busy_q - 20'h00001;
            end
        end
    end

    always_comb begin
        status = 8'h00;
        status[`NBWP_ST_OIP] = op_in_progress;
        status[`NBWP_ST_WEL] = wel_q;
        status[`NBWP_ST_EFAIL] = efail_q;
        status[`NBWP_ST_PFAIL] = pfail_q;
    end

    assign feat_m = '{rng: range_q, cfg: cfg_q, status: status,
                      qlock: lock_q[qblk_q]};

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_rst_locks_all: assert property ($past(rst) |-> &lock_q)
        else $error("lock bits not all set after reset");
    a_glob_lock: assert property (take && idle &&
        fr.op == `NBWP_OP_GLB_LOCK |=> (&lock_q) && op_in_progress)
        else $error("global lock failed");
    a_glob_unlock: assert property (take && idle &&
        fr.op == `NBWP_OP_GLB_UNLOCK |=> (lock_q == '0) && op_in_progress)
        else $error("global unlock failed");
    a_block_lock: assert property (take && idle &&
        fr.op == `NBWP_OP_BLK_LOCK |=> lock_q[$past(blk_a)] && op_in_progress)
        else $error("block lock failed");
    a_block_unlock: assert property (take && idle &&
        fr.op == `NBWP_OP_BLK_UNLOCK |=> !lock_q[$past(blk_a)] && op_in_progress)
        else $error("block unlock failed");
    a_busy_keeps: assert property (take && !idle &&
        (is_lock_op(fr.op) || fr.op == `NBWP_OP_SETF)
        |=> $stable(lock_q) && $stable(range_q))
        else $error("protection changed while busy");
    a_oip_span: assert property (take && idle && is_lock_op(fr.op)
        |=> op_in_progress [*2]) else $error("lock busy too short");
    a_erase_fail: assert property (take && idle && wel_q &&
        prot_row && fr.op == `NBWP_OP_BLK_ERASE |=> efail_q && !wel_q && op_in_progress)
        else $error("erase of locked region not flagged");
    a_prog_fail: assert property (take && idle && wel_q &&
        prot_row && fr.op == `NBWP_OP_PROG_EXEC |=> pfail_q && !wel_q && op_in_progress)
        else $error("program of protected region not flagged");
    a_reset_abort: assert property (take && fr.op == `NBWP_OP_RESET
        |=> op_in_progress && (&lock_q) && !efail_q && !pfail_q)
        else $error("reset command did not abort");
    a_range_all: assert property (!cfg_q[`NBWP_CFG_SCHEME] &&
        range_q[`NBWP_RNG_BP_HI:`NBWP_RNG_BP_LO] == `NBWP_BP_ALL |-> prot_row)
        else $error("extent 111 does not protect all");
    a_scheme_sel: assert property (cfg_q[`NBWP_CFG_SCHEME]
        |-> prot_row == lock_q[row_a[16:6]])
        else $error("block lock scheme not applied");
endmodule

// *** rtl/nbwp_map.svh ***
// Opcodes, feature addresses, field positions, reset values and timing
`ifndef NBWP_MAP_SVH
`define NBWP_MAP_SVH

`define NBWP_OP_RESET 8'hFF
`define NBWP_OP_GETF 8'h0F
`define NBWP_OP_SETF 8'h1F
`define NBWP_OP_WREN 8'h06
`define NBWP_OP_WRDI 8'h04
`define NBWP_OP_BLK_LOCK 8'h36
`define NBWP_OP_BLK_UNLOCK 8'h39
`define NBWP_OP_LOCK_QUERY 8'h3D
`define NBWP_OP_GLB_LOCK 8'h7E
`define NBWP_OP_GLB_UNLOCK 8'h98
`define NBWP_OP_PROG_EXEC 8'h10
`define NBWP_OP_BLK_ERASE 8'hD8

`define NBWP_FA_RANGE 8'hA0
`define NBWP_FA_CONFIG 8'hB0
`define NBWP_FA_STATUS 8'hC0

`define NBWP_RANGE_RST 8'h38
`define NBWP_CONFIG_RST 8'h00

`define NBWP_CFG_SCHEME 5
`define NBWP_RNG_CMP 1
`define NBWP_RNG_INV 2
`define NBWP_RNG_BP_HI 5
`define NBWP_RNG_BP_LO 3

`define NBWP_ST_OIP 0
`define NBWP_ST_WEL 1
`define NBWP_ST_EFAIL 2
`define NBWP_ST_PFAIL 3

`define NBWP_BP_NONE 3'h0
`define NBWP_BP_ALL 3'h7
`define NBWP_BP_BLOCK0 3'h6
`define NBWP_ROWS 18'h20000
`define NBWP_BLOCK0_ROWS 18'h00040
`define NBWP_ONE_ROW 18'h00001
`define NBWP_FRAC_SHIFT 5'h0A

`define NBWP_BITS_OP 6'h08
`define NBWP_BITS_FEAT 6'h18
`define NBWP_BITS_ADDR 6'h20
`define NBWP_EDGE_FA 6'h0F
`define NBWP_EDGE_QBLK 6'h13
`define NBWP_OUT_FEAT 6'h10
`define NBWP_OUT_QUERY 6'h20
`define NBWP_CNT_TOP 6'h3F
`define NBWP_CNT_WRAP 6'h38

`define NBWP_CLK_NS 8

`endif

// *** rtl/nbwp_pkg.sv ***
// Types shared by the block write protection design
package nbwp_pkg;
    typedef enum logic [0:0] {
        NBWP_IDLE = 1'b0,
        NBWP_BUSY = 1'b1
    } nbwp_state_e;

    typedef struct packed {
        logic [7:0] op;
        logic [23:0] addr;
        logic [5:0] nbits;
    } nbwp_frame_s;

    typedef struct packed {
        logic [7:0] rng;
        logic [7:0] cfg;
        logic [7:0] status;
        logic qlock;
    } nbwp_feat_s;
endpackage

// *** rtl/nbwp_sync.sv ***
// Two flip-flop level synchroniser
`timescale 1ns/10ps

module nbwp_sync #(
    parameter int W = 1,
    parameter logic RST_BIT = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_chk
        $error("nbwp_sync: W must be at least 1");
    end

    // The first stage feeds only the second one
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_q <= {W{RST_BIT}};
            q <= {W{RST_BIT}};
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// *** test/nbwp_host_model.sv ***
// Serial host model that frames flash commands for the protection block
`timescale 1ns/10ps
`include "nbwp_map.svh"

module nbwp_host_model #(
    parameter int HALF_NS = 16
) (
    output logic sclk,
    output logic cs_n,
    output logic si,
    input wire logic so,
    input wire logic so_oe
);
    logic oe_seen;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        si = 1'b1;
        oe_seen = 1'b1;
        // A chip select rise at start gives the frame marker a known value
        #2;
        cs_n = 1'b1;
    end

    // Clock stands low outside frames; bits leave MSB first
    task automatic frame(input logic [31:0] w, input int nw, input int nr,
                         output logic [7:0] rd);
        rd = 8'h00;
        oe_seen = 1'b1;
        #3;
        cs_n = 1'b0;
        for (int i = 0; i < nw + nr; i++) begin
            if (i < nw) si = w[31 - i];
            else si = ~si;
            #(HALF_NS);
            if (i >= nw) begin
                rd = {rd[6:0], so};
                oe_seen = oe_seen & so_oe;
            end
            sclk = 1'b1;
            #(HALF_NS);
            sclk = 1'b0;
        end
        #(HALF_NS);
        cs_n = 1'b1;
        // Released line shows the inverse so stale bits cannot be reused
        si = ~si;
        #(3 * HALF_NS);
    endtask

    task automatic cmd(input logic [7:0] op);
        logic [7:0] r;
        frame({op, 24'h000000}, 8, 0, r);
    endtask

    task automatic setf(input logic [7:0] fa, input logic [7:0] d);
        logic [7:0] r;
        frame({`NBWP_OP_SETF, fa, d, 8'h00}, 24, 0, r);
    endtask

    task automatic getf(input logic [7:0] fa, output logic [7:0] rd);
        frame({`NBWP_OP_GETF, fa, 16'h0000}, 16, 8, rd);
    endtask

    // Leading zero, block, then low row bits and dummies that must be ignored
    task automatic blk_op(input logic [7:0] op, input logic [10:0] blk,
                          input int nr, output logic [7:0] rd);
        frame({op, 1'b0, blk, 12'hA5C}, 32, nr, rd);
    endtask

    task automatic row_op(input logic [7:0] op, input logic [16:0] row);
        logic [7:0] r;
        frame({op, 7'h00, row}, 32, 0, r);
    endtask
endmodule

// *** test/tb_nbwp_top.sv ***
// Self-checking bench for the block write protection design
`timescale 1ns/10ps
`include "nbwp_map.svh"

module tb_nbwp_top;
    logic mclk;
    logic rst;
    logic sclk;
    logic cs_n;
    logic si;
    logic so;
    logic so_oe;
    int n_errors;
    int samples_checked;

    nbwp_top #(
        .LOCK_BUSY_NS(4000),
        .RESET_BUSY_NS(2000),
        .PROG_BUSY_NS(16),
        .ERASE_BUSY_NS(16)
    ) nbwp_top_i (
        .mclk(mclk),
        .rst(rst),
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .so_oe(so_oe)
    );

    nbwp_host_model nbwp_host_model_i (
        .sclk(sclk),
        .cs_n(cs_n),
        .si(si),
        .so(so),
        .so_oe(so_oe)
    );

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic status(output logic [7:0] s);
        nbwp_host_model_i.getf(`NBWP_FA_STATUS, s);
    endtask

    task automatic query(input logic [10:0] blk, input logic [7:0] exp);
        logic [7:0] r;
        nbwp_host_model_i.blk_op(`NBWP_OP_LOCK_QUERY, blk, 8, r);
        check(r, exp, "lock query");
        check({7'h0, nbwp_host_model_i.oe_seen}, 8'h01, "so oe");
    endtask

    task automatic busy_now(input string what);
        logic [7:0] s;
        status(s);
        check(s & 8'h01, 8'h01, what);
    endtask

    // Lock busy runs 500 cycles so refused commands land inside it
    task automatic wait_idle();
        logic [7:0] s;
        s = 8'h01;
        for (int i = 0; i < 40 && s[0] !== 1'b0; i++) status(s);
        check(s & 8'h01, 8'h00, "busy never ended");
    endtask

    task automatic probe(input logic [7:0] op, input logic [16:0] row,
                         input int bitn, input logic exp);
        logic [7:0] s;
        nbwp_host_model_i.cmd(`NBWP_OP_WREN);
        nbwp_host_model_i.row_op(op, row);
        status(s);
        check({7'h0, s[bitn]}, {7'h0, exp}, "fail flag");
    endtask

    function automatic logic prot(input logic [1:0] c, input logic [2:0] bp,
                                  input logic [16:0] row);
        logic [17:0] sz;
        sz = 18'h20000 >> (7 - bp);
        if (bp == 3'h0) return 1'b0;
        if (bp == 3'h7) return 1'b1;
        if (c[0] && bp == 3'h6) return row < 17'h00040;
        case (c)
            2'b00: return row >= 18'h20000 - sz;
            2'b10: return row < sz;
            2'b01: return row < 18'h20000 - sz;
            default: return row >= sz;
        endcase
    endfunction

    task automatic t_reset();
        logic [7:0] r;
        nbwp_host_model_i.getf(`NBWP_FA_RANGE, r);
        check(r, 8'h38, "range reset");
        nbwp_host_model_i.getf(`NBWP_FA_CONFIG, r);
        check(r, 8'h00, "config reset");
        status(r);
        check(r, 8'h00, "status reset");
        query(11'h000, 8'h01);
        query(11'h7FF, 8'h01);
        $display("test reset values done");
    endtask

    task automatic t_global();
        nbwp_host_model_i.cmd(`NBWP_OP_GLB_UNLOCK);
        busy_now("global unlock busy");
        wait_idle();
        query(11'h123, 8'h00);
        query(11'h000, 8'h00);
        nbwp_host_model_i.cmd(`NBWP_OP_GLB_LOCK);
        busy_now("global lock busy");
        wait_idle();
        query(11'h400, 8'h01);
        $display("test global lock done");
    endtask

    task automatic t_block();
        logic [7:0] r;
        nbwp_host_model_i.cmd(`NBWP_OP_GLB_UNLOCK);
        wait_idle();
        nbwp_host_model_i.blk_op(`NBWP_OP_BLK_LOCK, 11'h7FF, 0, r);
        busy_now("block lock busy");
        // Both of these land while busy and must change nothing
        nbwp_host_model_i.blk_op(`NBWP_OP_BLK_UNLOCK, 11'h7FF, 0, r);
        nbwp_host_model_i.setf(`NBWP_FA_RANGE, 8'h00);
        wait_idle();
        nbwp_host_model_i.getf(`NBWP_FA_RANGE, r);
        check(r, 8'h38, "range write while busy");
        query(11'h7FF, 8'h01);
        query(11'h7FE, 8'h00);
        nbwp_host_model_i.blk_op(`NBWP_OP_BLK_UNLOCK, 11'h7FF, 0, r);
        busy_now("block unlock busy");
        wait_idle();
        query(11'h7FF, 8'h00);
        $display("test block lock done");
    endtask

    task automatic t_scheme();
        logic [7:0] r;
        nbwp_host_model_i.setf(`NBWP_FA_CONFIG, 8'h20);
        nbwp_host_model_i.getf(`NBWP_FA_CONFIG, r);
        check(r, 8'h20, "scheme select");
        nbwp_host_model_i.blk_op(`NBWP_OP_BLK_LOCK, 11'h003, 0, r);
        wait_idle();
        probe(`NBWP_OP_PROG_EXEC, 17'h000C5, 3, 1'b1);
        probe(`NBWP_OP_PROG_EXEC, 17'h00100, 3, 1'b0);
        probe(`NBWP_OP_BLK_ERASE, 17'h000C0, 2, 1'b1);
        probe(`NBWP_OP_BLK_ERASE, 17'h00140, 2, 1'b0);
        nbwp_host_model_i.setf(`NBWP_FA_CONFIG, 8'h00);
        $display("test lock scheme done");
    endtask

    task automatic t_range();
        logic [17:0] sz;
        logic [16:0] rows[4];
        for (int c = 0; c < 4; c++) begin
            for (int bp = 0; bp < 8; bp++) begin
                sz = 18'h20000 >> (7 - bp);
                rows[0] = 17'(sz - 18'h1);
                rows[1] = sz[16:0];
                rows[2] = (bp == 6) ? 17'h0003F : 17'(18'h1FFFF - sz);
                rows[3] = (bp == 6) ? 17'h00040 : 17'(18'h20000 - sz);
                // Top bit set to show that only the three fields decide
                nbwp_host_model_i.setf(`NBWP_FA_RANGE,
                    {2'b10, 3'(bp), 1'(c >> 1), 1'(c), 1'b0});
                for (int k = 0; k < 4; k++) begin
                    probe(`NBWP_OP_PROG_EXEC, rows[k], 3,
                          prot(2'(c), 3'(bp), rows[k]));
                end
            end
        end
        $display("test range decode done");
    endtask

    task automatic t_rst();
        logic [7:0] s;
        nbwp_host_model_i.cmd(`NBWP_OP_WREN);
        nbwp_host_model_i.cmd(`NBWP_OP_GLB_UNLOCK);
        nbwp_host_model_i.cmd(`NBWP_OP_RESET);
        status(s);
        check(s & 8'h0F, 8'h01, "reset busy, flags cleared");
        wait_idle();
        query(11'h009, 8'h01);
        $display("test reset command done");
    endtask

    initial begin
        n_errors = 0;
        samples_checked = 0;
        rst = 1'b1;
        repeat (12) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        t_reset();
        t_global();
        t_block();
        t_scheme();
        t_range();
        t_rst();
        final_report();
    end

    // About 47k cycles expected; this bound only catches a hang
    initial begin
        repeat (95000) @(posedge mclk);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end
endmodule
